// [logic/anbmp_pkg.sv]
/*
 * anbmp_pkg: constants shared by the host-side controller of an
 * asynchronous byte-wide non-volatile memory port.
 * Assumes a single 250 MHz clock (4 ns period) in the host.
 */
package anbmp_pkg;

	// clock period in picoseconds
	localparam int unsigned CLK_PERIOD_PS   = 4000;

	// bus geometry
	localparam int unsigned ADDR_W          = 15;
	localparam int unsigned DATA_W          = 8;

	// documented times, in picoseconds (printed figures in ns times 1000), except the startup time in ns
	localparam int unsigned T_STEADY_HIGH_PS = 2000;     // strobe steady high
	localparam int unsigned T_CYCLE_PS       = 35000;    // min cycle time
	localparam int unsigned T_ACCESS_PS      = 35000;    // max address/enable access
	localparam int unsigned T_OE_ACCESS_PS   = 15000;    // max output enable access
	localparam int unsigned T_EHQZ_PS        = 15000;    // max release after enable high
	localparam int unsigned T_GHQZ_PS        = 10000;    // max release after oe high
	localparam int unsigned T_WPULSE_PS      = 15000;    // min write pulse
	localparam int unsigned T_ADDR_END_PS    = 20000;    // min address to end of write
	localparam int unsigned T_DATA_SETUP_PS  = 10000;    // min data valid to end
	localparam int unsigned T_RECOVERY_PS    = 12000;    // min write recovery
	localparam int unsigned T_STARTUP_NS     = 2000000;  // 2 ms startup

	// least times round up to whole cycles, except startup, which truncates
	localparam int unsigned CYC_STEADY   = (T_STEADY_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_CYCLE    = (T_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_ACCESS   = (T_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_RELEASE  = (T_EHQZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_WPULSE_A = (T_WPULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_ADDR_END = (T_ADDR_END_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_WPULSE   = (CYC_WPULSE_A > CYC_ADDR_END) ?
	                                       CYC_WPULSE_A : CYC_ADDR_END;
	localparam int unsigned CYC_RECOVERY = (T_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CYC_STARTUP  = (T_STARTUP_NS * 1000 / CLK_PERIOD_PS);

	// controller states
	typedef enum logic [2:0] {
		ANBMP_STARTUP,
		ANBMP_IDLE,
		ANBMP_RD_ACCESS,
		ANBMP_RD_RELEASE,
		ANBMP_WR_PULSE,
		ANBMP_WR_RECOVER,
		ANBMP_GAP
	} anbmp_state_t;

endpackage : anbmp_pkg

// [logic/anbmp_timer_if.sv]
/*
 * anbmp_timer_if: load/count/expiry bundle between the controller and
 * its interval timer. Assumes one clock domain.
 */
interface anbmp_timer_if #(
	parameter int unsigned CNT_W = 20
);
	logic             load;   // load a new count
	logic [CNT_W-1:0] value;  // cycles to wait, at least one
	logic             done;   // level: timer at zero

	modport ctrl  (output load, output value, input done);
	modport timer (input load, input value, output done);
endinterface : anbmp_timer_if

// [logic/anbmp_timer.sv]
/*
 * anbmp_timer: down counter that times every interval of the controller.
 * Assumes synchronous active-high reset on the shared clock.
 */
module anbmp_timer #(
	parameter int unsigned CNT_W = 20
) (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic srst_i,
	// control bundle
	anbmp_timer_if.timer tmr
);
	logic [CNT_W-1:0] cnt_r;   // remaining cycles
	logic [CNT_W-1:0] cnt_nxt;

	// count down to zero, reload on request
	assign cnt_nxt  = tmr.load ? tmr.value - CNT_W'(1) :
	                  (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
	assign tmr.done = (cnt_r == '0) && !tmr.load;

	// single register, cleared by reset
	always_ff @(posedge clock_i) begin
		if (srst_i) cnt_r <= '0;
		else        cnt_r <= cnt_nxt;
	end
endmodule : anbmp_timer

// [logic/anbmp_host.sv]
/*
 * anbmp_host: clocked host controller that drives the pins of an
 * asynchronous 32K x 8 non-volatile memory for single byte reads and writes.
 * Assumes pins are synchronous to clock_i (250 MHz) and the memory
 * powers up with srst_i; strobes hold high through the startup time.
 */
// Summary of operation
// [RL1] write only while select and strobe low
// [RL2] oe late after write keeps data tri-stated
// [RL3] strobes stay high 2 ns after rising
// [RL4] select falls at least 35 ns apart
// [RL5] read: strobe high, data by 35 ns
// [RL6] address valid before select falls; the code changes the address on the same edge as select falls
// [RL7] data within 15 ns of oe low
// [RL8] data held 3 ns after address change
// [RL9] no drive before 3 ns after select
// [RL10] release 15 ns select, 10 ns oe
// [RL11] address setup 0, valid 20 ns to end
// [RL12] strobe-ended write pulse at least 15 ns
// [RL13] select-ended write low at least 15 ns
// [RL14] data valid 10 ns before end
// [RL15] address held 12 ns write recovery
// [RL16] memory releases within 12 ns of strobe
// [RL17] select-ended write keeps outputs tri-stated
// [RL18] hold strobes high 2 ms after power
// [RL19] round intervals up, sample after access
module anbmp_host #(
	parameter int unsigned ADDR_W      = anbmp_pkg::ADDR_W,
	parameter int unsigned DATA_W      = anbmp_pkg::DATA_W,
	parameter int unsigned STARTUP_CYC = anbmp_pkg::CYC_STARTUP
) (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              srst_i,
	// user request side
	input  wire logic              req_i,       // level: request pending
	input  wire logic              req_we_i,    // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] req_addr_i,  // byte address
	input  wire logic [DATA_W-1:0] req_wdata_i, // write byte
	output logic                   req_ack_o,   // pulse: request taken
	output logic                   rd_valid_o,  // pulse: read byte ready
	output logic [DATA_W-1:0]      rd_data_o,   // read byte
	output logic                   ready_o,     // level: startup done, idle
	// memory pins
	output logic [ADDR_W-1:0]      mem_addr_o,  // address lines
	output logic                   mem_sel_n_o, // chip select, low active
	output logic                   mem_we_n_o,  // write strobe, low active
	output logic                   mem_oe_n_o,  // output enable, low active
	input  wire logic [DATA_W-1:0] mem_dq_i,    // data lines in
	output logic [DATA_W-1:0]      mem_dq_o,    // data lines out
	output logic                   mem_dq_oe_o  // high while host drives dq
);
	localparam int unsigned CNT_W = 20;

	// refuse settings the fixed-width timer or the buses cannot serve
	initial begin
		if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CNT_W)) $error("startup count out of range");
		if (ADDR_W < 1 || DATA_W < 1) $error("bus widths must be positive");
	end

	anbmp_timer_if #(.CNT_W(CNT_W)) tmr ();

	anbmp_timer #(.CNT_W(CNT_W)) u_timer (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.tmr     (tmr)
	);

	anbmp_pkg::anbmp_state_t state_r;      // controller state
	anbmp_pkg::anbmp_state_t state_nxt;
	logic [CNT_W-1:0]        gap_r;        // cycles since select fell
	logic [CNT_W-1:0]        gap_nxt;
	logic                    start_r;      // pulse to timer on entry to any state but idle
	logic [CNT_W-1:0]        load_val_r;   // count for that load
	logic [ADDR_W-1:0]       addr_r;
	logic                    sel_n_r;
	logic                    we_n_r;
	logic                    oe_n_r;
	logic [DATA_W-1:0]       wdata_r;
	logic                    dq_oe_r;
	logic                    ack_r;
	logic                    rvalid_r;
	logic [DATA_W-1:0]       rdata_r;
	logic                    ready_r;

	// decoded events
	wire logic take_req   = (state_r == anbmp_pkg::ANBMP_IDLE) && req_i && tmr.done;
	wire logic timer_done = tmr.done && !start_r;
	// remaining cycles so consecutive select falls keep the cycle time
	wire logic [CNT_W-1:0] cycle_cyc = CNT_W'(anbmp_pkg::CYC_CYCLE);
	wire logic [CNT_W-1:0] gap_left  = (gap_r >= cycle_cyc) ? CNT_W'(1) : cycle_cyc - gap_r;
	wire logic [CNT_W-1:0] recov_cyc = CNT_W'(anbmp_pkg::CYC_RECOVERY);
	wire logic [CNT_W-1:0] steady_cyc = CNT_W'(anbmp_pkg::CYC_STEADY);
	wire logic [CNT_W-1:0] after_cyc = (gap_left > steady_cyc) ? gap_left : steady_cyc;

	assign tmr.load  = start_r;
	assign tmr.value = load_val_r;

	// count cycles from the last falling select, saturating
	assign gap_nxt = take_req ? CNT_W'(1) :
	                 (gap_r != '1) ? gap_r + CNT_W'(1) : gap_r;

	// next state; each wait is a whole timer interval
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			anbmp_pkg::ANBMP_STARTUP:    if (timer_done) state_nxt = anbmp_pkg::ANBMP_IDLE;
			anbmp_pkg::ANBMP_IDLE: begin
				if (take_req) begin
					state_nxt = req_we_i ? anbmp_pkg::ANBMP_WR_PULSE : anbmp_pkg::ANBMP_RD_ACCESS;
				end
			end
			anbmp_pkg::ANBMP_RD_ACCESS:  if (timer_done) state_nxt = anbmp_pkg::ANBMP_RD_RELEASE;
			anbmp_pkg::ANBMP_RD_RELEASE: if (timer_done) state_nxt = anbmp_pkg::ANBMP_GAP;
			anbmp_pkg::ANBMP_WR_PULSE:   if (timer_done) state_nxt = anbmp_pkg::ANBMP_WR_RECOVER;
			anbmp_pkg::ANBMP_WR_RECOVER: if (timer_done) state_nxt = anbmp_pkg::ANBMP_GAP;
			anbmp_pkg::ANBMP_GAP:        if (timer_done) state_nxt = anbmp_pkg::ANBMP_IDLE;
			default:                     state_nxt = anbmp_pkg::ANBMP_STARTUP;
		endcase
	end

	// state, gap counter and timer loads
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_r    <= anbmp_pkg::ANBMP_STARTUP;
			gap_r      <= '1;
			start_r    <= 1'b1;                              // see [RL18]
			load_val_r <= CNT_W'(STARTUP_CYC);
		end else begin
			state_r <= state_nxt;
			gap_r   <= gap_nxt;
			start_r <= (state_nxt != state_r) && (state_nxt != anbmp_pkg::ANBMP_IDLE);
			unique case (state_nxt)
				anbmp_pkg::ANBMP_RD_ACCESS:  load_val_r <= CNT_W'(anbmp_pkg::CYC_ACCESS);  // see [RL5]
				anbmp_pkg::ANBMP_RD_RELEASE: load_val_r <= CNT_W'(anbmp_pkg::CYC_RELEASE); // see [RL10]
				anbmp_pkg::ANBMP_WR_PULSE:   load_val_r <= CNT_W'(anbmp_pkg::CYC_WPULSE);  // see [RL12]
				anbmp_pkg::ANBMP_WR_RECOVER: load_val_r <= recov_cyc;                      // see [RL15]
				anbmp_pkg::ANBMP_GAP:        load_val_r <= after_cyc;                      // see [RL4]
				default:                     load_val_r <= load_val_r;
			endcase
		end
	end

	// pin drive; on a write select and strobe fall together, rise together
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			addr_r  <= '0;
			sel_n_r <= 1'b1;                                 // see [RL18]
			we_n_r  <= 1'b1;
			oe_n_r  <= 1'b1;
			wdata_r <= '0;
			dq_oe_r <= 1'b0;
		end else begin
			if (take_req) begin
				addr_r  <= req_addr_i;                       // see [RL6] see [RL11]
				wdata_r <= req_wdata_i;                      // see [RL14]
				sel_n_r <= 1'b0;                             // see [RL1]
				we_n_r  <= !req_we_i;                        // see [RL5]
				oe_n_r  <= req_we_i;                         // see [RL2]
				dq_oe_r <= req_we_i;
			end else if (timer_done && (state_r == anbmp_pkg::ANBMP_RD_ACCESS ||
			                            state_r == anbmp_pkg::ANBMP_WR_PULSE)) begin
				// end of access: strobes high, address and data held
				sel_n_r <= 1'b1;                             // see [RL3]
				we_n_r  <= 1'b1;                             // see [RL13]
				oe_n_r  <= 1'b1;
			end else if (timer_done && state_r == anbmp_pkg::ANBMP_WR_RECOVER) begin
				dq_oe_r <= 1'b0;                             // hold of 0 ns met with margin
			end
		end
	end

	// user answers; data sampled only after full access time
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ack_r    <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			ready_r  <= 1'b0;
		end else begin
			ack_r    <= take_req;
			rvalid_r <= timer_done && (state_r == anbmp_pkg::ANBMP_RD_ACCESS); // see [RL19]
			if (timer_done && state_r == anbmp_pkg::ANBMP_RD_ACCESS) begin
				rdata_r <= mem_dq_i;                         // see [RL7] see [RL8]
			end
			ready_r  <= (state_nxt == anbmp_pkg::ANBMP_IDLE);
		end
	end

	// outputs straight from flip-flops
	assign req_ack_o   = ack_r;
	assign rd_valid_o  = rvalid_r;
	assign rd_data_o   = rdata_r;
	assign ready_o     = ready_r;
	assign mem_addr_o  = addr_r;
	assign mem_sel_n_o = sel_n_r;
	assign mem_we_n_o  = we_n_r;
	assign mem_oe_n_o  = oe_n_r;
	assign mem_dq_o    = wdata_r;
	assign mem_dq_oe_o = dq_oe_r;
endmodule : anbmp_host

// [tb/anbmp_host_monitor.sv]
/* anbmp_host_monitor: pin timing checks on the host controller.
 * Assumes registered pins on clock_i and a synchronous srst_i. */
module anbmp_host_monitor #(
	parameter int unsigned STARTUP_CYC = 20
) (
	// clock and reset
	input wire logic                         clock_i,
	input wire logic                         srst_i,
	// watched outputs
	input wire logic                         rd_valid_o,
	input wire logic [anbmp_pkg::ADDR_W-1:0] mem_addr_o,
	input wire logic                         mem_sel_n_o,
	input wire logic                         mem_we_n_o,
	input wire logic                         mem_oe_n_o,
	input wire logic [anbmp_pkg::DATA_W-1:0] mem_dq_o,
	input wire logic                         mem_dq_oe_o
);
	localparam int GAP_MIN = anbmp_pkg::CYC_CYCLE - 1;  // edges between falls
	int unsigned boot_cnt_r;  // cycles since reset
	int unsigned gap_cnt_r;   // cycles since select fell
	int unsigned low_cnt_r;   // sampled cycles of select low
	logic        sel_q_r;     // select one sample back
	wire         sel_fall = sel_q_r && !mem_sel_n_o;
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// counters kept apart from the design so a slip there shows here
	always_ff @(posedge clock_i) begin
		sel_q_r    <= srst_i | mem_sel_n_o;
		boot_cnt_r <= srst_i ? 0 : boot_cnt_r + 1;
		gap_cnt_r  <= (srst_i || sel_fall) ? 0 : gap_cnt_r + 1;
		low_cnt_r  <= sel_fall ? 1 : low_cnt_r + 32'(!mem_sel_n_o);
	end
	property p_boot; boot_cnt_r < STARTUP_CYC |-> mem_sel_n_o && mem_we_n_o; endproperty
	a_boot: assert property (p_boot) else $error("strobe low during startup");
	property p_gap; sel_fall |-> gap_cnt_r >= GAP_MIN; endproperty
	a_gap: assert property (p_gap) else $error("select falls too close");
	property p_acc; rd_valid_o |-> low_cnt_r >= anbmp_pkg::CYC_ACCESS; endproperty
	a_acc: assert property (p_acc) else $error("read sampled too early");
	property p_rd; !mem_oe_n_o |-> mem_we_n_o && !mem_dq_oe_o; endproperty
	a_rd: assert property (p_rd) else $error("read with strobe or drive");
	property p_wr; !mem_we_n_o |-> !mem_sel_n_o && mem_oe_n_o; endproperty
	a_wr: assert property (p_wr) else $error("strobe low outside select");
	property p_pulse; $fell(mem_we_n_o) |-> (!mem_we_n_o && !mem_sel_n_o)[*5]; endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse short");
	property p_hold;
		(!mem_sel_n_o && !sel_fall) |->
			$stable(mem_addr_o) && (mem_we_n_o || ($stable(mem_dq_o) && mem_dq_oe_o));
	endproperty
	a_hold: assert property (p_hold) else $error("address or data moved");
	property p_rec; $rose(mem_we_n_o) |-> $stable(mem_addr_o)[*3]; endproperty
	a_rec: assert property (p_rec) else $error("address moved in recovery");
	property p_steady; $rose(mem_sel_n_o) |=> mem_sel_n_o && mem_we_n_o; endproperty
	a_steady: assert property (p_steady) else $error("strobe pulsed low");
	property p_rel; $rose(mem_oe_n_o) |-> !mem_dq_oe_o[*4]; endproperty
	a_rel: assert property (p_rel) else $error("drive before release");
	c_read: cover property (rd_valid_o);
	c_write: cover property ($fell(mem_we_n_o));
	c_tight: cover property (sel_fall && gap_cnt_r == GAP_MIN);
endmodule : anbmp_host_monitor

bind anbmp_host anbmp_host_monitor #(.STARTUP_CYC(STARTUP_CYC)) u_mon (
	.clock_i(clock_i), .srst_i(srst_i), .rd_valid_o(rd_valid_o),
	.mem_addr_o(mem_addr_o), .mem_sel_n_o(mem_sel_n_o), .mem_we_n_o(mem_we_n_o),
	.mem_oe_n_o(mem_oe_n_o), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o));

// [tb/anbmp_mem_model.sv]
/* anbmp_mem_model: behavioural 32K x 8 memory at the far side.
 * Assumes level pins from the host; it also resolves the data bus. */
module anbmp_mem_model (
	// control pins
	input wire logic        sel_n_i,
	input wire logic        we_n_i,
	input wire logic        oe_n_i,
	input wire logic [14:0] addr_i,
	// host data
	input wire logic [7:0]  hd_i,
	input wire logic        hoe_i,
	// resolved bus
	output logic [7:0]      bus_o,
	output logic            drv_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:32767];  // storage
	logic [7:0] last = 8'h00;   // last level really driven
	logic       ok = 1'b0;      // access time has run
	// drive only in a plain read, never under a write strobe
	assign drv_o = !sel_n_i && !oe_n_i && we_n_i && ok;
	// a floating bus shows the inverse of its last level, never a kind value
	assign bus_o = drv_o ? mem[addr_i] : (hoe_i ? hd_i : ~last);
	always @* begin
		if (drv_o || hoe_i)
			last = bus_o;
	end
	// data only valid a full access time after select falls
	always @(sel_n_i) begin
		ok = 1'b0;
		if (!sel_n_i) begin
			#35;
			ok = !sel_n_i;
		end
	end
	// byte stored when the overlap of select and strobe ends
	always @(posedge (sel_n_i | we_n_i))
		mem[addr_i] <= bus_o;
endmodule : anbmp_mem_model

// [tb/anbmp_host_bench.sv]
/* anbmp_host_bench: random and corner byte traffic through the host.
 * Assumes the memory model and a startup shortened to 20 cycles. */
module anbmp_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SU = 20;  // short startup keeps the run brief
	logic        clock_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        req_i = 1'b1;  // raised early: must wait out startup
	logic        req_we_i = 1'b1;
	logic [14:0] req_addr_i = 15'h7fff;
	logic [7:0]  req_wdata_i = 8'h00;
	wire         req_ack_o, rd_valid_o, ready_o, sel_n, we_n, oe_n, dq_oe, drv;
	wire  [14:0] addr;
	wire  [7:0]  rd_data_o, dq_o, bus;
	logic [7:0]  shadow [0:32767];  // expected contents
	logic [14:0] used [0:15];       // addresses written so far
	logic [7:0]  last_rd;           // last byte read
	logic        have_rd = 1'b0;
	logic [31:0] seed = 32'h0000_c970;
	int          err_count = 0;
	int          n_checks = 0;
	always #2 clock_i = ~clock_i;
	anbmp_host #(.STARTUP_CYC(SU)) DUT (
		.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i), .req_we_i(req_we_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ack_o(req_ack_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .ready_o(ready_o),
		.mem_addr_o(addr), .mem_sel_n_o(sel_n), .mem_we_n_o(we_n), .mem_oe_n_o(oe_n),
		.mem_dq_i(bus), .mem_dq_o(dq_o), .mem_dq_oe_o(dq_oe));
	anbmp_mem_model u_mem (.sel_n_i(sel_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr),
		.hd_i(dq_o), .hoe_i(dq_oe), .bus_o(bus), .drv_o(drv));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one byte; request left up so the next call runs back to back
	task automatic xfer(input logic we, input logic [14:0] a, input logic [7:0] d,
		output int n);
		req_we_i = we;
		req_addr_i = a;
		req_wdata_i = d;
		req_i = 1'b1;
		n = 0;
		// let an edge pass first: the previous call's ack may still stand here
		do begin
			@(negedge clock_i);
			n++;
		end while (req_ack_o !== 1'b1 && n < 1000);
		check("request acked", 8'(req_ack_o === 1'b1), 8'h01);
		if (we) begin
			shadow[a] = d;
			if (have_rd)
				check("held read byte", rd_data_o, last_rd);
		end else begin
			for (int k = 0; k < 40 && rd_valid_o !== 1'b1; k++)
				@(negedge clock_i);
			check("read valid", 8'(rd_valid_o === 1'b1), 8'h01);
			check("read byte", rd_data_o, shadow[a]);
			last_rd = shadow[a];
			have_rd = 1'b1;
		end
	endtask : xfer
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	// the host must never drive while the memory does
	always @(posedge clock_i) begin
		if (drv && dq_oe)
			check("dq contention", 8'h01, 8'h00);
	end
	initial begin
		#20000;
		err_count++;
		final_report();
	end
	initial begin
		int n;
		repeat (20) @(negedge clock_i);
		srst_i = 1'b0;
		xfer(1'b1, 15'h7fff, 8'h00, n);
		check("startup wait", 8'(n >= SU), 8'h01);
		xfer(1'b1, 15'h0000, 8'hff, n);
		xfer(1'b0, 15'h7fff, 8'h00, n);
		xfer(1'b0, 15'h0000, 8'h00, n);
		for (int i = 0; i < 32; i++) begin
			if (i % 2 == 0) begin
				used[i / 2] = 15'(xs());
				xfer(1'b1, used[i / 2], 8'(xs()), n);
			end else
				xfer(1'b0, used[xs() % (i / 2 + 1)], 8'h00, n);
		end
		req_i = 1'b0;
		repeat (20) @(negedge clock_i);
		// with no request left the controller must settle back to idle
		check("idle ready", 8'(ready_o === 1'b1), 8'h01);
		final_report();
	end
endmodule : anbmp_host_bench
